// ---- testbench/pth_tester_model.sv ----
/*
 * Behavioural model of the external tester on the strobe/completion link.
 * Assumes its polarity settings mirror the prober's configuration.
 */
`timescale 1ns/1ps
`default_nettype none
module pth_tester_model (
	// Clock
	input wire logic clk,
	// Handshake
	input wire logic trig_out,
	output logic trig_in,
	// Behaviour
	input wire logic out_low,
	input wire logic in_low,
	input wire logic respond,
	input wire logic [7:0] delay
);
	logic [7:0] cnt;
	initial begin
		cnt = 8'h00;
		trig_in = 1'b1;
	end
	// Reading takes delay cycles; done only after it is stored
	always @(posedge clk) begin
		if ((trig_out ^ out_low) && respond) begin
			cnt <= cnt + 8'h01;
			trig_in <= (cnt >= delay) ? ~in_low : in_low;
		end else begin
			cnt <= 8'h00;
			trig_in <= in_low;
		end
	end
endmodule : pth_tester_model
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench: AXI4-Lite tasks, motion stub, tester model.
 * Assumes pth_top with a 10-cycle millisecond tick.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pth_pkg::*;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, contact;
	logic awready, wready, bvalid, arready, rvalid, probe_lower, trig_out, trig_in, busy, irq;
	logic [7:0] awaddr, araddr, t_delay;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] idx;
	logic out_low, in_low, t_en, drop;
	int failures, check_count, strobes, strobe_len, run_len;

	pth_top #(.TICK_CYCLES_P(10)) pth_top_inst (.CORE_CLK(clk), .RESET(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PROBE_LOWER(probe_lower),
		.PROBE_CONTACT(contact), .POINT_IDX(idx), .TRIG_OUT(trig_out),
		.TRIG_IN(trig_in), .BUSY(busy), .IRQ(irq));
	pth_tester_model pth_tester_model_inst (.clk(clk), .trig_out(trig_out),
		.trig_in(trig_in), .out_low(out_low), .in_low(in_low), .respond(t_en),
		.delay(t_delay));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Motion stub: contact follows lowering one cycle later; drop breaks contact
	always @(posedge clk) contact <= probe_lower && !drop;
	// Strobe watch: never active with the probe raised; run lengths
	always @(negedge clk) begin
		if (!rst && busy === 1'b1 && probe_lower === 1'b0 && trig_out !== out_low) begin
			failures++;
			$display("wrong value strobe_raised expected %b seen %b", out_low, trig_out);
		end
		if (trig_out === !out_low) run_len++;
		else if (run_len != 0) begin
			strobes++;
			strobe_len = run_len;
			run_len = 0;
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw = 1'b0;
		w = 1'b0;
		while (!(aw && w)) begin
			@(posedge clk);
			if (awready === 1'b1 && !aw) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		rv = rdata;
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask : rd

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, RESP_OKAY);
		chk("register", exp, rv);
	endtask : rdchk

	task automatic cfg(input logic [31:0] v);
		wr(OFS_CFG, v, RESP_OKAY);
		out_low <= v[1];
		in_low <= v[2];
		repeat (3) @(posedge clk);
		strobes = 0;
		run_len = 0;
		chk("idle strobe", {31'h0, out_low}, {31'h0, trig_out});
	endtask : cfg

	task automatic scan(input logic [31:0] n);
		int k;
		wr(OFS_POINTS, n, RESP_OKAY);
		wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		k = 0;
		@(posedge clk);
		while (busy !== 1'b0 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		chk("busy", 32'h0, {31'h0, busy});
	endtask : scan

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (50000) @(posedge clk);
		failures++;
		$display("wrong value watchdog expected done seen hang");
		summarize;
	end

	initial begin
		rst = 1'b1;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		drop = 1'b0;
		out_low = 1'b0;
		in_low = 1'b1;
		t_en = 1'b1;
		t_delay = 8'h04;
		failures = 0;
		check_count = 0;
		strobes = 0;
		run_len = 0;
		strobe_len = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rdchk(OFS_CFG, 32'h0000_0005);
		rdchk(OFS_POINTS, 32'h0000_0040);
		rdchk(OFS_DWELL, 32'h0000_00C8);
		rdchk(OFS_TIMEOUT, 32'h0000_0064);
		rdchk(OFS_IRQ_MASK, 32'h0000_0000);
		rd(8'h20, RESP_SLVERR);
		wr(8'h20, 32'h0000_0001, RESP_SLVERR);
		$display("test reset values done");
		// Tester handshake, default polarities; reading well inside timeout
		wr(OFS_IRQ_MASK, 32'h0000_0007, RESP_OKAY);
		wr(OFS_TIMEOUT, 32'h0000_0005, RESP_OKAY);
		strobes = 0;
		scan(32'h0000_0003);
		chk("point idx", 32'h0000_0002, {16'h0, idx});
		chk("strobe count", 32'd3, strobes);
		chk("strobe len", 32'h1, {31'h0, strobe_len inside {[5:7]}});
		chk("irq", 32'h1, {31'h0, irq});
		rd(OFS_IRQ_STAT, RESP_OKAY);
		chk("scan event", 32'h0000_0002, rv & 32'h0000_0006);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rdchk(OFS_IRQ_STAT, 32'h0000_0000);
		$display("test handshake done");
		// Inverted polarities on both lines
		cfg(32'h0000_0003);
		scan(32'h0000_0002);
		chk("strobe count", 32'd2, strobes);
		chk("strobe len", 32'h1, {31'h0, strobe_len inside {[5:7]}});
		$display("test polarity done");
		// Dwell only; completion ignored though tester answers fast
		cfg(32'h0000_0000);
		wr(OFS_DWELL, 32'h0000_0002, RESP_OKAY);
		scan(32'h0000_0002);
		chk("strobe count", 32'd2, strobes);
		chk("dwell len", 32'h1, {31'h0, strobe_len inside {[20:22]}});
		$display("test dwell done");
		// Silent tester: timeout ends the scan on the first point
		cfg(32'h0000_0005);
		t_en <= 1'b0;
		wr(OFS_TIMEOUT, 32'h0000_0003, RESP_OKAY);
		rd(OFS_IRQ_STAT, RESP_OKAY);
		strobes = 0;
		scan(32'h0000_0004);
		chk("strobe count", 32'd1, strobes);
		chk("timeout len", 32'h1, {31'h0, strobe_len inside {[30:32]}});
		chk("point idx", 32'h0, {16'h0, idx});
		rd(OFS_IRQ_STAT, RESP_OKAY);
		chk("timeout event", 32'h0000_0004, rv & 32'h0000_0006);
		$display("test timeout done");
		// Abort in mid-strobe: idle, no events
		wr(OFS_TIMEOUT, 32'h0000_0032, RESP_OKAY);
		wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		repeat (20) @(posedge clk);
		rdchk(OFS_STATUS, 32'h0000_0005);
		wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
		repeat (3) @(posedge clk);
		chk("abort busy", 32'h0, {31'h0, busy});
		chk("abort strobe", {31'h0, out_low}, {31'h0, trig_out});
		rdchk(OFS_IRQ_STAT, 32'h0000_0000);
		$display("test abort done");
		// Contact lost in mid-strobe: lift, point counted, single-point scan ends
		wr(OFS_POINTS, 32'h0000_0001, RESP_OKAY);
		wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
		repeat (20) @(posedge clk);
		drop <= 1'b1;
		repeat (5) @(posedge clk);
		chk("lost busy", 32'h0, {31'h0, busy});
		chk("lost strobe", {31'h0, out_low}, {31'h0, trig_out});
		rdchk(OFS_IRQ_STAT, 32'h0000_0003);
		drop <= 1'b0;
		$display("test contact loss done");
		summarize;
	end
endmodule : testbench
`default_nettype wire

// ---- verilog/pth_pkg.sv ----
/*
 * Constants, register map and carrier types of the prober-tester handshake.
 * Assumes a single 20 MHz core clock and 32-bit AXI4-Lite register access.
 */
package pth_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MS_NS = 1_000_000;
	localparam int unsigned TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_POINTS = 8'h08;
	localparam logic [7:0] OFS_DWELL = 8'h0C;
	localparam logic [7:0] OFS_TIMEOUT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_ABORT_BIT = 1;
	localparam int CFG_TIN_EN_BIT = 0;
	localparam int CFG_OUT_LOW_BIT = 1;
	localparam int CFG_IN_LOW_BIT = 2;
	localparam int EVT_POINT_BIT = 0;
	localparam int EVT_SCAN_BIT = 1;
	localparam int EVT_TMO_BIT = 2;
	localparam int STATUS_IDX_LSB = 16;

	// ----------------------------------------------------------------
	// Reset values and AXI response codes
	// ----------------------------------------------------------------
	localparam logic [15:0] POINTS_RST = 16'h0040;
	localparam logic [15:0] DWELL_RST = 16'h00C8;
	localparam logic [15:0] TIMEOUT_RST = 16'h0064;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic in_low;
		logic out_low;
		logic tin_en;
	} pth_cfg_t;

	localparam pth_cfg_t CFG_RST = '{in_low: 1'b1, out_low: 1'b0, tin_en: 1'b1};

	typedef struct packed {
		logic tmo;
		logic scan;
		logic point;
	} pth_evt_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOWER = 2'b01,
		ST_STROBE = 2'b10,
		ST_LIFT = 2'b11
	} pth_state_t;
endpackage : pth_pkg

// ---- verilog/pth_tick.sv ----
/*
 * Millisecond tick generator for the handshake dwell and timeout counters.
 * Assumes the caller restarts it whenever a timed wait begins.
 */
`timescale 1ns/1ps
`default_nettype none
module pth_tick #(
	parameter int unsigned CYCLES = 20000
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic restart,
	output logic tick
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] cnt;

	always_ff @(posedge clk) begin
		if (rst || restart) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt == LAST) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule : pth_tick
`default_nettype wire

// ---- verilog/pth_top.sv ----
/*
 * Prober side of the tester handshake: point sequencer, strobe output,
 * completion input, dwell and timeout timing, AXI4-Lite registers, interrupt.
 * Assumes motion logic lowers the probe while PROBE_LOWER is high and reports
 * contact on PROBE_CONTACT; all inputs are synchronous to CORE_CLK.
 */
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
// Behaviour
// - The strobe output is active only while the probe is lowered onto the current point.
// - The completion input idles high by default and its active level lifts the probe.
// - Both strobe output and completion input have a software-selectable active level.
// - With the completion input disabled, the probe stays down dwell ms, then lifts and advances.
// - While waiting for completion a ms timeout runs; expiry flags an error.
// - With the completion input disabled, only the dwell timer, a loss of contact or an abort ends the point.
// - Lower, strobe, wait and advance repeat until every taught point is visited or a completion timeout or an abort ends the scan.
// - Active-high strobe idles low; active-low strobe idles high.
// - The completion input level is polarity-selected and has its own enable.
`timescale 1ns/1ps
`default_nettype none
module pth_top
	import pth_pkg::*;
#(
	parameter int unsigned TICK_CYCLES_P = pth_pkg::TICK_CYCLES,
	parameter int IDX_W = 16
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET,
	// AXI4-Lite write
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Motion
	output logic PROBE_LOWER,
	input wire logic PROBE_CONTACT,
	output logic [IDX_W-1:0] POINT_IDX,
	// Tester handshake
	output logic TRIG_OUT,
	input wire logic TRIG_IN,
	// Status
	output logic BUSY,
	output logic IRQ
);
	import pth_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pth_state_t state, next_state;
	pth_cfg_t cfg;
	pth_evt_t evt, irq_stat, irq_mask;
	logic [15:0] points, dwell, timeout, ms_cnt;
	logic start_req, abort_req;
	logic tick, restart, expire, tin_act, last_point;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go, rd_go, stat_rd;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign wr_go = aw_held && w_held && !S_AXI_BVALID;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			S_AXI_AWREADY <= S_AXI_AWVALID && !S_AXI_AWREADY && !aw_held;
			S_AXI_WREADY <= S_AXI_WVALID && !S_AXI_WREADY && !w_held;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end else if (wr_go) begin
				aw_held <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end else if (wr_go) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= RESP_OKAY;
		end else if (wr_go) begin
			S_AXI_BVALID <= 1'b1;
			if (aw_addr <= OFS_IRQ_MASK && aw_addr[1:0] == 2'b00) begin
				S_AXI_BRESP <= RESP_OKAY;
			end else begin
				S_AXI_BRESP <= RESP_SLVERR;
			end
		end else if (S_AXI_BREADY) begin
			S_AXI_BVALID <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			cfg <= CFG_RST;
			points <= POINTS_RST;
			dwell <= DWELL_RST;
			timeout <= TIMEOUT_RST;
			irq_mask <= IRQ_MASK_RST;
			start_req <= 1'b0;
			abort_req <= 1'b0;
		end else begin
			start_req <= 1'b0;
			abort_req <= 1'b0;
			if (wr_go) begin
				if (aw_addr == OFS_CTRL) begin
					start_req <= w_strb[0] && w_data[CTRL_START_BIT];
					abort_req <= w_strb[0] && w_data[CTRL_ABORT_BIT];
				end else if (aw_addr == OFS_CFG && w_strb[0]) begin
					cfg <= pth_cfg_t'(w_data[2:0]);
				end else if (aw_addr == OFS_POINTS) begin
					points <= merge16(points, w_data, w_strb);
				end else if (aw_addr == OFS_DWELL) begin
					dwell <= merge16(dwell, w_data, w_strb);
				end else if (aw_addr == OFS_TIMEOUT) begin
					timeout <= merge16(timeout, w_data, w_strb);
				end else if (aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
					irq_mask <= pth_evt_t'(w_data[2:0]);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
	assign stat_rd = rd_go && S_AXI_ARADDR == OFS_IRQ_STAT;

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= RESP_OKAY;
		end else begin
			S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
			if (rd_go) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= RESP_OKAY;
				if (S_AXI_ARADDR == OFS_CTRL) begin
					S_AXI_RDATA <= 32'h0000_0000;
				end else if (S_AXI_ARADDR == OFS_CFG) begin
					S_AXI_RDATA <= {29'h0, cfg};
				end else if (S_AXI_ARADDR == OFS_POINTS) begin
					S_AXI_RDATA <= {16'h0000, points};
				end else if (S_AXI_ARADDR == OFS_DWELL) begin
					S_AXI_RDATA <= {16'h0000, dwell};
				end else if (S_AXI_ARADDR == OFS_TIMEOUT) begin
					S_AXI_RDATA <= {16'h0000, timeout};
				end else if (S_AXI_ARADDR == OFS_STATUS) begin
					S_AXI_RDATA <= {16'(POINT_IDX), 13'h0, state, BUSY};
				end else if (S_AXI_ARADDR == OFS_IRQ_STAT) begin
					S_AXI_RDATA <= {29'h0, irq_stat};
				end else if (S_AXI_ARADDR == OFS_IRQ_MASK) begin
					S_AXI_RDATA <= {29'h0, irq_mask};
				end else begin
					S_AXI_RDATA <= 32'h0000_0000;
					S_AXI_RRESP <= RESP_SLVERR;
				end
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Millisecond timing
	// ----------------------------------------------------------------
	pth_tick #(
		.CYCLES(TICK_CYCLES_P)
	) u_tick (
		.clk(CORE_CLK),
		.rst(RESET),
		.restart(restart),
		.tick(tick)
	);

	// Timer restarts on every entry to the strobe phase
	assign restart = next_state == ST_STROBE && state != ST_STROBE;
	assign expire = tick && (ms_cnt + 16'h0001) >= (cfg.tin_en ? timeout : dwell);
	assign tin_act = TRIG_IN ^ cfg.in_low;
	assign last_point = (16'(POINT_IDX) + 16'h0001) >= points;

	always_ff @(posedge CORE_CLK) begin
		if (RESET || restart) begin
			ms_cnt <= 16'h0000;
		end else if (tick) begin
			ms_cnt <= ms_cnt + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Point sequencer
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		evt = '0;
		case (state)
			ST_IDLE: begin
				if (start_req && points != 16'h0000) begin
					next_state = ST_LOWER;
				end
			end
			ST_LOWER: begin
				if (PROBE_CONTACT) begin
					next_state = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (!PROBE_CONTACT) begin
					next_state = ST_LIFT;
				end else if (cfg.tin_en && tin_act) begin
					next_state = ST_LIFT;
				end else if (expire && cfg.tin_en) begin
					next_state = ST_IDLE;
					evt.tmo = 1'b1;
				end else if (expire) begin
					next_state = ST_LIFT;
				end
			end
			ST_LIFT: begin
				if (!PROBE_CONTACT) begin
					evt.point = 1'b1;
					evt.scan = last_point;
					next_state = last_point ? ST_IDLE : ST_LOWER;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (abort_req) begin
			next_state = ST_IDLE;
			evt = '0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			POINT_IDX <= '0;
		end else if (state == ST_IDLE && start_req) begin
			POINT_IDX <= '0;
		end else if (evt.point && !evt.scan && !abort_req) begin
			POINT_IDX <= POINT_IDX + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			PROBE_LOWER <= 1'b0;
			TRIG_OUT <= CFG_RST.out_low;
			BUSY <= 1'b0;
		end else begin
			PROBE_LOWER <= next_state == ST_LOWER || next_state == ST_STROBE;
			TRIG_OUT <= (next_state == ST_STROBE) ^ cfg.out_low;
			BUSY <= next_state != ST_IDLE;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt status, read clears, set wins
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (RESET) begin
			irq_stat <= '0;
			IRQ <= 1'b0;
		end else begin
			irq_stat <= (stat_rd ? pth_evt_t'(3'h0) : irq_stat) | evt;
			IRQ <= |(((stat_rd ? pth_evt_t'(3'h0) : irq_stat) | evt) & irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	strobe_contact_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		(TRIG_OUT ^ cfg.out_low) && $stable(cfg) |-> PROBE_LOWER && $past(PROBE_CONTACT))
		else $error("strobe active without contact");

	done_lifts_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state == ST_STROBE && PROBE_CONTACT && cfg.tin_en && tin_act && !abort_req
		|=> state == ST_LIFT && !PROBE_LOWER)
		else $error("completion did not lift probe");

	strobe_level_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state == ST_IDLE && $past(state) == ST_IDLE && $stable(cfg) |-> TRIG_OUT == cfg.out_low)
		else $error("strobe idle level wrong");

	dwell_end_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state == ST_LIFT && $past(state) == ST_STROBE && !$past(cfg.tin_en) &&
		$past(PROBE_CONTACT) && !$past(abort_req) |-> $past(expire))
		else $error("dwell ended early");

	timeout_err_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state == ST_STROBE && PROBE_CONTACT && cfg.tin_en && !tin_act && expire && !abort_req
		|=> state == ST_IDLE && irq_stat.tmo && !BUSY)
		else $error("timeout not flagged");

	ignore_done_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state == ST_STROBE && PROBE_CONTACT && !cfg.tin_en && !expire && !abort_req
		|=> state == ST_STROBE)
		else $error("input not ignored while dwelling");

	scan_end_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		state == ST_LIFT && !PROBE_CONTACT && last_point && !abort_req
		|=> state == ST_IDLE && irq_stat.scan && irq_stat.point)
		else $error("scan did not finish on last point");

	tick_gap_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		tick |=> !tick)
		else $error("tick lasted more than one cycle");

	irq_level_a: assert property (@(posedge CORE_CLK) disable iff (RESET)
		##1 IRQ == |($past(irq_stat | evt) & $past(irq_mask)) || $past(stat_rd))
		else $error("interrupt level mismatch");
endmodule : pth_top
`default_nettype wire
